// ### inc/flash_host_map.svh
// Timing figures and pin field positions for the flash host controller
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

`define FH_CLK_PERIOD_NS 100
`define FH_ACCESS_NS 90
`define FH_SLEEP_EXTRA_NS 30
`define FH_ADDR_SETUP_NS 50
`define FH_WE_PULSE_NS 50
`define FH_PROT_PULSE_NS 100000
`define FH_VID_SETTLE_NS 4000
`define FH_CLEAR_PULSE_NS 500
`define FH_CLEAR_HIGH_READ_NS 50
`define FH_READY_NS 20000
`define FH_SYNC_LATENCY 3

`define FH_ADDR_BIT_ZERO 0
`define FH_ADDR_BIT_ONE 1
`define FH_ADDR_BIT_SIX 6
`define FH_GROUP_LSB 16
`define FH_GROUP_MSB 21

`endif

// ### inc/flash_host_pkg.sv
// Types shared by the flash host controller
package flash_host_pkg;
    typedef enum logic [3:0] {
        OP_READ = 4'h0,
        OP_WRITE = 4'h1,
        OP_STANDBY = 4'h2,
        OP_HW_RESET = 4'h3,
        OP_GROUP_PROTECT = 4'h4,
        OP_CHIP_UNPROTECT = 4'h5,
        OP_PROTECT_VERIFY = 4'h6,
        OP_READ_ID = 4'h7,
        OP_TEMP_UNPROTECT = 4'h8
    } op_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_STROBE = 3'h3,
        ST_HOLD = 3'h2,
        ST_RST_LOW = 3'h6,
        ST_RST_REC = 3'h7
    } state_e;
endpackage

// ### inc/flash_sample_if.sv
// Synchronised flash pin levels passed from the sampler to the controller
`timescale 1ns/1ps
interface flash_sample_if #(parameter int DW = 16);
    logic [DW-1:0] dq;
    logic readyBusyN;
    modport sampler (output dq, output readyBusyN);
    modport ctrl (input dq, input readyBusyN);
endinterface

// ### rtl/flash_pin_sampler.sv
// Three-stage sampler for flash pins arriving from outside the clock domain
`timescale 1ns/1ps
module flash_pin_sampler #(
    parameter int DW = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [DW-1:0] dqIn,
    input wire logic readyBusyN,
    flash_sample_if.sampler smp
);
    localparam int NB = DW + 1;
    // Ready pin idles high, so reset to that level to avoid a false busy
    localparam logic [NB-1:0] IdleLvl = {1'b1, {DW{1'b0}}};
    logic [NB-1:0] raw;
    logic [NB-1:0] s1_reg, s2_reg, s3_reg, val_reg;
    logic [NB-1:0] val_next;

    assign raw = {readyBusyN, dqIn};

    // Accept a level only once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < NB; i++) begin : g_bit
            assign val_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : val_reg[i];
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= IdleLvl;
            s2_reg <= IdleLvl;
            s3_reg <= IdleLvl;
            val_reg <= IdleLvl;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            val_reg <= val_next;
        end
    end

    // Agreed level passed on at once; registering it again costs a cycle
    assign smp.dq = val_next[DW-1:0];
    assign smp.readyBusyN = val_next[DW];
endmodule

// ### rtl/flash_host_ctrl.sv
// Host-side controller driving a parallel NOR flash through its pins
`timescale 1ns/1ps
`include "flash_host_map.svh"

module flash_host_ctrl #(
    parameter int AW = 22,
    parameter int DW = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmdValid,
    input wire flash_host_pkg::op_e cmdOp,
    input wire logic [AW-1:0] cmdAddr,
    input wire logic [DW-1:0] cmdData,
    input wire logic wpEnable,
    output logic cmdReady,
    output logic rspValid,
    output logic [DW-1:0] rspData,
    output logic retryNeeded,
    output logic flashCeN,
    output logic flashOeN,
    output logic flashWeN,
    output logic flashResetN,
    output logic flashWpN,
    output logic [AW-1:0] flashAddr,
    output logic [DW-1:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [DW-1:0] flashDqIn,
    input wire logic readyBusyN,
    output logic vidAddrNine,
    output logic vidOutEn,
    output logic vidReset
);
    import flash_host_pkg::*;

    function automatic logic [15:0] cycUp(input int ns);
        int c;
        c = (ns + `FH_CLK_PERIOD_NS - 1) / `FH_CLK_PERIOD_NS;
        if (c < 1) c = 1;
        return 16'(c);
    endfunction

    function automatic logic [15:0] cycDown(input int ns);
        int c;
        c = ns / `FH_CLK_PERIOD_NS;
        if (c < 1) c = 1;
        return 16'(c);
    endfunction

    // Read strobe also covers the sampler latency
    localparam logic [15:0] AccessCyc = cycUp(`FH_ACCESS_NS) + 16'(`FH_SYNC_LATENCY);
    localparam logic [15:0] SleepCyc = cycUp(`FH_ACCESS_NS + `FH_SLEEP_EXTRA_NS);
    localparam logic [15:0] SetupCyc = cycUp(`FH_ADDR_SETUP_NS);
    localparam logic [15:0] WeCyc = cycUp(`FH_WE_PULSE_NS);
    localparam logic [15:0] ProtCyc = cycUp(`FH_PROT_PULSE_NS);
    localparam logic [15:0] VidCyc = cycUp(`FH_VID_SETTLE_NS);
    localparam logic [15:0] ClearCyc = cycUp(`FH_CLEAR_PULSE_NS);
    localparam logic [15:0] RhCyc = cycUp(`FH_CLEAR_HIGH_READ_NS);
    localparam logic [15:0] ReadyCyc = cycDown(`FH_READY_NS);

    flash_sample_if #(.DW(DW)) smp ();

    flash_pin_sampler #(.DW(DW)) u_sampler (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .dqIn(flashDqIn),
        .readyBusyN(readyBusyN),
        .smp(smp)
    );

    state_e state_reg, state_next;
    op_e op_reg, op_next;
    logic [15:0] cnt_reg, cnt_next;
    logic cmdReady_reg, cmdReady_next;
    logic rspValid_reg, rspValid_next;
    logic [DW-1:0] rspData_reg, rspData_next;
    logic retry_reg, retry_next;
    logic ceN_reg, ceN_next;
    logic oeN_reg, oeN_next;
    logic weN_reg, weN_next;
    logic resetN_reg, resetN_next;
    logic wpN_reg, wpN_next;
    logic [AW-1:0] addr_reg, addr_next;
    logic [DW-1:0] dq_reg, dq_next;
    logic dqOe_reg, dqOe_next;
    logic vidNine_reg, vidNine_next;
    logic vidOe_reg, vidOe_next;
    logic vidRst_reg, vidRst_next;

    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        cnt_next = cnt_reg;
        cmdReady_next = cmdReady_reg;
        rspValid_next = 1'b0;
        rspData_next = rspData_reg;
        retry_next = retry_reg;
        ceN_next = ceN_reg;
        oeN_next = oeN_reg;
        weN_next = weN_reg;
        resetN_next = resetN_reg;
        wpN_next = ~wpEnable;
        addr_next = addr_reg;
        dq_next = dq_reg;
        dqOe_next = dqOe_reg;
        vidNine_next = vidNine_reg;
        vidOe_next = vidOe_reg;
        vidRst_next = vidRst_reg;
        // any accepted write retires the retry request
        if (state_reg == ST_IDLE && cmdValid && cmdOp == OP_WRITE) begin
            retry_next = 1'b0;
        end
        case (state_reg)
            ST_IDLE: begin
                if (cmdValid) begin
                    op_next = cmdOp;
                    cmdReady_next = 1'b0;
                    addr_next = cmdAddr;
                    oeN_next = 1'b1;
                    weN_next = 1'b1;
                    cnt_next = SetupCyc;
                    state_next = ST_SETUP;
                    ceN_next = 1'b0;
                    case (cmdOp)
                        OP_STANDBY: begin
                            // chip enable and clear both high
                            ceN_next = 1'b1;
                            resetN_next = 1'b1;
                            cnt_next = 16'h0001;
                            state_next = ST_HOLD;
                        end
                        OP_HW_RESET: begin
                            // hold clear low a full pulse
                            resetN_next = 1'b0;
                            vidRst_next = 1'b0;
                            cnt_next = ClearCyc;
                            state_next = ST_RST_LOW;
                            // busy at abort, flag for restart
                            if (!smp.readyBusyN) begin
                                retry_next = 1'b1;
                            end
                        end
                        OP_TEMP_UNPROTECT: begin
                            // high voltage on clear pin as level
                            vidRst_next = cmdData[0];
                            cnt_next = VidCyc;
                            state_next = ST_HOLD;
                        end
                        OP_WRITE: begin
                            // data out only with output enable high
                            dq_next = cmdData;
                            dqOe_next = 1'b1;
                        end
                        OP_GROUP_PROTECT: begin
                            // high voltage, bit six low, bit one high
                            vidNine_next = 1'b1;
                            vidOe_next = 1'b1;
                            addr_next[`FH_ADDR_BIT_SIX] = 1'b0;
                            addr_next[`FH_ADDR_BIT_ONE] = 1'b1;
                            addr_next[`FH_ADDR_BIT_ZERO] = 1'b0;
                            cnt_next = VidCyc;
                        end
                        OP_CHIP_UNPROTECT: begin
                            vidNine_next = 1'b1;
                            vidOe_next = 1'b1;
                            addr_next[`FH_ADDR_BIT_SIX] = 1'b1;
                            addr_next[`FH_ADDR_BIT_ONE] = 1'b1;
                            addr_next[`FH_ADDR_BIT_ZERO] = 1'b0;
                            cnt_next = VidCyc;
                        end
                        OP_PROTECT_VERIFY: begin
                            // group on upper bits, bit one high
                            vidNine_next = 1'b1;
                            addr_next = '0;
                            addr_next[`FH_GROUP_MSB:`FH_GROUP_LSB] = cmdAddr[`FH_GROUP_MSB:`FH_GROUP_LSB];
                            addr_next[`FH_ADDR_BIT_ONE] = 1'b1;
                            cnt_next = VidCyc;
                        end
                        OP_READ_ID: begin
                            // bit zero picks maker or device code
                            vidNine_next = 1'b1;
                            addr_next[`FH_ADDR_BIT_SIX] = 1'b0;
                            addr_next[`FH_ADDR_BIT_ONE] = 1'b0;
                            cnt_next = VidCyc;
                        end
                        default: begin
                            dqOe_next = 1'b0;
                        end
                    endcase
                end
            end
            ST_SETUP: begin
                if (cnt_reg > 16'h0001) begin
                    cnt_next = cnt_reg - 16'h0001;
                end else begin
                    state_next = ST_STROBE;
                    if (op_reg == OP_WRITE) begin
                        weN_next = 1'b0;
                        cnt_next = WeCyc;
                    end else if (op_reg == OP_GROUP_PROTECT || op_reg == OP_CHIP_UNPROTECT) begin
                        weN_next = 1'b0;
                        cnt_next = ProtCyc;
                    end else begin
                        // data released in the same cycle that output enable falls
                        dqOe_next = 1'b0;
                        oeN_next = 1'b0;
                        cnt_next = AccessCyc;
                    end
                end
            end
            ST_STROBE: begin
                if (cnt_reg > 16'h0001) begin
                    cnt_next = cnt_reg - 16'h0001;
                end else begin
                    if (!oeN_reg) begin
                        // address held so sleeping data stays valid
                        rspData_next = smp.dq;
                    end
                    oeN_next = 1'b1;
                    weN_next = 1'b1;
                    cnt_next = 16'h0001;
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_reg > 16'h0001) begin
                    cnt_next = cnt_reg - 16'h0001;
                end else begin
                    dqOe_next = 1'b0;
                    vidNine_next = 1'b0;
                    vidOe_next = 1'b0;
                    if (op_reg != OP_READ && op_reg != OP_READ_ID && op_reg != OP_PROTECT_VERIFY) begin
                        rspData_next = '0;
                    end
                    rspValid_next = 1'b1;
                    cmdReady_next = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_RST_LOW: begin
                if (cnt_reg > 16'h0001) begin
                    cnt_next = cnt_reg - 16'h0001;
                end else begin
                    // release; reads held off for at least RhCyc
                    resetN_next = 1'b1;
                    cnt_next = '0;
                    state_next = ST_RST_REC;
                end
            end
            ST_RST_REC: begin
                cnt_next = cnt_reg + 16'h0001;
                // then ready/busy, bounded by ready time
                if (cnt_reg + 16'h0001 >= RhCyc && (smp.readyBusyN || cnt_reg + 16'h0001 >= ReadyCyc)) begin
                    rspData_next = '0;
                    rspValid_next = 1'b1;
                    cmdReady_next = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                cmdReady_next = 1'b1;
            end
        endcase
    end

    // Sleep needs no action; held address lets the device doze after SleepCyc
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            op_reg <= OP_READ;
            cnt_reg <= '0;
            cmdReady_reg <= 1'b1;
            rspValid_reg <= 1'b0;
            rspData_reg <= '0;
            retry_reg <= 1'b0;
            ceN_reg <= 1'b1;
            oeN_reg <= 1'b1;
            weN_reg <= 1'b1;
            resetN_reg <= 1'b1;
            wpN_reg <= 1'b1;
            addr_reg <= '0;
            dq_reg <= '0;
            dqOe_reg <= 1'b0;
            vidNine_reg <= 1'b0;
            vidOe_reg <= 1'b0;
            vidRst_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            cnt_reg <= cnt_next;
            cmdReady_reg <= cmdReady_next;
            rspValid_reg <= rspValid_next;
            rspData_reg <= rspData_next;
            retry_reg <= retry_next;
            ceN_reg <= ceN_next;
            oeN_reg <= oeN_next;
            weN_reg <= weN_next;
            resetN_reg <= resetN_next;
            wpN_reg <= wpN_next;
            addr_reg <= addr_next;
            dq_reg <= dq_next;
            dqOe_reg <= dqOe_next;
            vidNine_reg <= vidNine_next;
            vidOe_reg <= vidOe_next;
            vidRst_reg <= vidRst_next;
        end
    end

    assign cmdReady = cmdReady_reg;
    assign rspValid = rspValid_reg;
    assign rspData = rspData_reg;
    assign retryNeeded = retry_reg;
    assign flashCeN = ceN_reg;
    assign flashOeN = oeN_reg;
    assign flashWeN = weN_reg;
    assign flashResetN = resetN_reg;
    assign flashWpN = wpN_reg;
    assign flashAddr = addr_reg;
    assign flashDqOut = dq_reg;
    assign flashDqOe = dqOe_reg;
    assign vidAddrNine = vidNine_reg;
    assign vidOutEn = vidOe_reg;
    assign vidReset = vidRst_reg;
endmodule

// ### verif/flash_ctrl_monitor.sv
// Port-level checker for the flash host controller
`timescale 1ns/1ps
module flash_ctrl_monitor #(
    parameter int AW = 22,
    parameter int DW = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmdValid,
    input wire flash_host_pkg::op_e cmdOp,
    input wire logic [AW-1:0] cmdAddr,
    input wire logic [DW-1:0] cmdData,
    input wire logic wpEnable,
    input wire logic cmdReady,
    input wire logic rspValid,
    input wire logic [DW-1:0] rspData,
    input wire logic retryNeeded,
    input wire logic flashCeN,
    input wire logic flashOeN,
    input wire logic flashWeN,
    input wire logic flashResetN,
    input wire logic flashWpN,
    input wire logic [AW-1:0] flashAddr,
    input wire logic [DW-1:0] flashDqOut,
    input wire logic flashDqOe,
    input wire logic [DW-1:0] flashDqIn,
    input wire logic readyBusyN,
    input wire logic vidAddrNine,
    input wire logic vidOutEn,
    input wire logic vidReset
);
    import flash_host_pkg::*;
    logic take;
    assign take = cmdValid && cmdReady;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    property p_dq_oe;
        flashDqOe |-> flashOeN;
    endproperty
    a_dq_oe: assert property (p_dq_oe) else $error("data driven with output enable low");
    property p_standby_quiet;
        flashCeN && flashResetN |-> !flashDqOe;
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) else $error("data driven in standby");
    property p_write_pins;
        !flashWeN |-> !flashCeN && flashOeN;
    endproperty
    a_write_pins: assert property (p_write_pins) else $error("write strobe with bad enables");
    property p_wp_follow;
        $past(rst_n) |-> flashWpN == !$past(wpEnable);
    endproperty
    a_wp_follow: assert property (p_wp_follow) else $error("write-protect pin lags input");
    property p_clear_len;
        $fell(flashResetN) |-> !flashResetN [*5];
    endproperty
    a_clear_len: assert property (p_clear_len) else $error("clear pulse too short");
    property p_read_gap;
        $rose(flashResetN) |-> flashOeN [*2];
    endproperty
    a_read_gap: assert property (p_read_gap) else $error("read too soon after clear");
    property p_read_time;
        take && cmdOp == OP_READ |=> !cmdReady [*6] ##1 (rspValid && cmdReady);
    endproperty
    a_read_time: assert property (p_read_time) else $error("read answer timing");
    property p_clear_bound;
        take && cmdOp == OP_HW_RESET |-> ##[7:210] rspValid;
    endproperty
    a_clear_bound: assert property (p_clear_bound) else $error("clear answer late");
    property p_retry_clear;
        take && cmdOp == OP_WRITE |=> !retryNeeded;
    endproperty
    a_retry_clear: assert property (p_retry_clear) else $error("retry flag kept after write");
    property p_prot_pins;
        $fell(flashWeN) && vidAddrNine |-> vidOutEn && !flashCeN && flashOeN;
    endproperty
    a_prot_pins: assert property (p_prot_pins) else $error("protect pulse with bad pins");
    c_read: cover property (take && cmdOp == OP_READ);
    c_retry: cover property (take && cmdOp == OP_HW_RESET && !readyBusyN);
    c_prot: cover property ($fell(flashWeN) && vidAddrNine);
endmodule

bind flash_host_ctrl flash_ctrl_monitor #(.AW(AW), .DW(DW)) u_mon (.*);

// ### verif/flash_dev_model.sv
// Behavioural flash device facing the host controller
`timescale 1ns/1ps
module flash_dev_model #(
    parameter int READY_NS = 5000,
    parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
    parameter logic [15:0] PART_CODE = 16'h1234 // Arbitrary value
) (
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic resetN,
    input wire logic [21:0] addr,
    input wire logic [15:0] hostQ,
    input wire logic hostOe,
    input wire logic vidAddrNine,
    input wire logic vidOutEn,
    input wire logic busyReq,
    output logic [15:0] dq,
    output logic readyBusyN
);
    logic [31:0] groupProt = '0;
    logic [15:0] devQ;
    logic [15:0] lastQ = 16'h0000;
    logic devOe;
    initial readyBusyN = 1'b1;
    assign devOe = resetN && !ceN && !oeN && weN;
    // always array read, status or codes
    always_comb begin
        if (!vidAddrNine) devQ = addr[15:0] ^ 16'h3c5a;
        else if (addr[1]) devQ = {15'h0000, groupProt[addr[21:17]]};
        else devQ = addr[0] ? PART_CODE : MAKER_CODE;
    end
    always @(devQ or devOe) if (devOe) lastQ = devQ;
    // Released line shows inverse, not a stale copy
    assign dq = hostOe ? hostQ : devOe ? devQ : ~lastQ;
    always @(posedge weN) begin
        if (vidAddrNine && vidOutEn && !ceN) begin
            if (addr[6]) groupProt = '0;
            else groupProt[addr[21:17]] = 1'b1;
        end
    end
    always @(posedge busyReq) readyBusyN = 1'b0;
    always @(negedge resetN) begin
        if (!readyBusyN) begin
            #(READY_NS);
            readyBusyN = 1'b1;
        end
    end
endmodule

// ### verif/tb_flash_host_ctrl.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb_flash_host_ctrl;
    import flash_host_pkg::*;
    localparam logic [15:0] MAKER = 16'h00a5;
    localparam logic [15:0] PART = 16'h1234;
    logic core_clk, rst_n, cmdValid, wpEnable, busyReq;
    op_e cmdOp;
    logic [21:0] cmdAddr, flashAddr;
    logic [15:0] cmdData, rspData, flashDqOut, flashDqIn;
    logic cmdReady, rspValid, retryNeeded, flashCeN, flashOeN, flashWeN, flashResetN, flashWpN;
    logic flashDqOe, readyBusyN, vidAddrNine, vidOutEn, vidReset;
    int n_mismatch = 0;
    int num_checks = 0;
    int lat;
    flash_host_ctrl dut (.*);
    flash_dev_model #(.READY_NS(5000), .MAKER_CODE(MAKER), .PART_CODE(PART)) dev (
        .ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN), .resetN(flashResetN), .addr(flashAddr),
        .hostQ(flashDqOut), .hostOe(flashDqOe), .vidAddrNine(vidAddrNine), .vidOutEn(vidOutEn),
        .busyReq(busyReq), .dq(flashDqIn), .readyBusyN(readyBusyN));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic tick;
        @(posedge core_clk);
        #10;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One request, waits for its answer under a bound
    task automatic issue(input op_e op, input logic [21:0] a, input logic [15:0] d);
        for (int i = 0; i < 300 && cmdReady !== 1'b1; i++) tick();
        cmdOp = op;
        cmdAddr = a;
        cmdData = d;
        cmdValid = 1'b1;
        tick();
        cmdValid = 1'b0;
        for (lat = 1; lat < 1200 && rspValid !== 1'b1; lat++) tick();
        if (lat >= 1200) begin
            n_mismatch++;
            results();
        end
    endtask
    task automatic t_idle;
        check({cmdReady, flashCeN, flashOeN, flashWeN, flashResetN, flashDqOe, rspValid}, 7'h7c);
    endtask
    task automatic t_read_write;
        issue(OP_READ, 22'h012345, 16'h0000);
        check(lat, 7);
        check(rspData, 16'h2345 ^ 16'h3c5a);
        issue(OP_READ, 22'h012346, 16'h0000);
        check(rspData, 16'h2346 ^ 16'h3c5a);
        issue(OP_WRITE, 22'h000555, 16'h00aa);
        check(lat, 4);
        issue(OP_STANDBY, 22'h000000, 16'h0000);
        check({flashCeN, flashResetN, flashDqOe}, 3'h6);
        issue(OP_READ, 22'h000777, 16'h0000);
        check(rspData, 16'h0777 ^ 16'h3c5a);
    endtask
    task automatic t_ids;
        for (int i = 0; i < 2; i++) begin
            issue(OP_READ_ID, {21'h000000, i[0]}, 16'h0000);
            check(rspData, (i == 1) ? PART : MAKER);
        end
    endtask
    task automatic t_protect;
        issue(OP_PROTECT_VERIFY, 22'h0a0000, 16'h0000);
        check(rspData, 16'h0000);
        issue(OP_GROUP_PROTECT, 22'h0a0002, 16'h0000);
        issue(OP_PROTECT_VERIFY, 22'h0a0000, 16'h0000);
        check(rspData, 16'h0001);
        issue(OP_PROTECT_VERIFY, 22'h0b0000, 16'h0000);
        check(rspData, 16'h0001);
        issue(OP_PROTECT_VERIFY, 22'h0c0000, 16'h0000);
        check(rspData, 16'h0000);
        for (int g = 0; g < 32; g++) issue(OP_GROUP_PROTECT, 22'(g) << 17, 16'h0000);
        issue(OP_PROTECT_VERIFY, 22'h0c0000, 16'h0000);
        check(rspData, 16'h0001);
        issue(OP_CHIP_UNPROTECT, 22'h000042, 16'h0000);
        issue(OP_PROTECT_VERIFY, 22'h0a0000, 16'h0000);
        check(rspData, 16'h0000);
    endtask
    task automatic t_clear;
        issue(OP_HW_RESET, 22'h000000, 16'h0000);
        check(lat >= 7 && lat < 12, 1'b1);
        check(retryNeeded, 1'b0);
        busyReq = 1'b1;
        repeat (5) tick();
        issue(OP_HW_RESET, 22'h000000, 16'h0000);
        busyReq = 1'b0;
        check(lat > 50 && lat < 210, 1'b1);
        check(retryNeeded, 1'b1);
        issue(OP_READ, 22'h000100, 16'h0000);
        check(rspData, 16'h0100 ^ 16'h3c5a);
        issue(OP_WRITE, 22'h000555, 16'h00aa);
        check(retryNeeded, 1'b0);
    endtask
    task automatic t_temp_wp;
        issue(OP_TEMP_UNPROTECT, 22'h000000, 16'h0001);
        check(vidReset, 1'b1);
        issue(OP_TEMP_UNPROTECT, 22'h000000, 16'h0000);
        check(vidReset, 1'b0);
        wpEnable = 1'b1;
        repeat (2) tick();
        check(flashWpN, 1'b0);
        wpEnable = 1'b0;
        repeat (2) tick();
        check(flashWpN, 1'b1);
    endtask
    initial begin
        rst_n = 1'b0;
        cmdValid = 1'b0;
        cmdOp = OP_READ;
        cmdAddr = 22'h000000;
        cmdData = 16'h0000;
        wpEnable = 1'b0;
        busyReq = 1'b0;
        repeat (12) @(posedge core_clk);
        #10;
        rst_n = 1'b1;
        tick();
        t_idle();
        t_read_write();
        t_ids();
        t_protect();
        t_clear();
        t_temp_wp();
        results();
    end
endmodule
